/* dv/rsl_ctrl_checker.sv */
/*
 * Concurrent checks on the ports of rsl_ctrl.
 * Assumes the interval parameters are handed on from the bound instance.
 */
`default_nettype none

module rsl_ctrl_checker #(
    parameter [23:0] LAMP_CYCLES = 24'h32,
    parameter [23:0] LONG_CYCLES = 24'h28,
    parameter [23:0] STRETCH_CYCLES = 24'h0a
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reset_source_select,
    input wire logic ext_reset_in_n,
    input wire logic [7:0] port_rx_act,
    input wire logic [7:0] port_collision,
    input wire logic [7:0] port_link_ok,
    input wire logic [7:0] port_partitioned,
    input wire logic repeater_run_q,
    input wire logic [7:0] traffic_bar_led_n,
    input wire logic alert_led_n,
    input wire logic any_activity_led_n,
    input wire logic any_collision_led_n,
    input wire logic [7:0] compat_led_n,
    input wire logic [7:0] port_led_a,
    input wire logic [7:0] port_led_b
);
    logic [23:0] rcnt;
    logic [23:0] icnt;
    logic [23:0] pcnt;

    // Cycles in run, cycles since activity, cycles of partition
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rcnt <= 24'h0;
            icnt <= 24'hffffff;
            pcnt <= 24'h0;
        end
        else
        begin
            rcnt <= !repeater_run_q ? 24'h0 : rcnt + {23'h0, rcnt != 24'hffffff};
            icnt <= |port_rx_act ? 24'h0 : icnt + {23'h0, icnt != 24'hffffff};
            pcnt <= |port_partitioned ? pcnt + {23'h0, pcnt != 24'hffffff} : 24'h0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_ext_held;
        (reset_source_select && !ext_reset_in_n) [*3];
    endsequence

    sequence s_col_end;
        $fell(|port_collision);
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    AST_RESET_OUT:
        assert property (!repeater_run_q |-> traffic_bar_led_n == 8'h00 && !alert_led_n
            && !any_activity_led_n && compat_led_n == 8'hff && port_led_b == 8'h00)
            else $error("outputs wrong while in reset");
    AST_LAMP_OUT:
        assert property (repeater_run_q && rcnt < LAMP_CYCLES |-> compat_led_n == 8'h00
            && traffic_bar_led_n == 8'h00 && !any_collision_led_n && port_led_b == 8'h00)
            else $error("lamp test outputs wrong");
    AST_EXT_RESET:
        assert property (s_ext_held |-> !repeater_run_q) else $error("external reset ignored");
    AST_PORT_COLOUR:
        assert property (repeater_run_q && rcnt > LAMP_CYCLES |->
            port_led_a == ~($past(port_link_ok) & $past(port_partitioned))
            && port_led_b == ~($past(port_link_ok) & ~$past(port_partitioned)))
            else $error("port colour wrong");
    AST_COMPAT_LINK:
        assert property (repeater_run_q && rcnt > LAMP_CYCLES |->
            compat_led_n == ~$past(port_link_ok)) else $error("legacy indicator wrong");
    AST_BAR_FILL:
        assert property ((~traffic_bar_led_n & (~traffic_bar_led_n + 8'h01)) == 8'h00)
            else $error("bargraph not filled from the bottom");
    AST_ACT_ONSET:
        assert property (|port_rx_act |-> ##2 !any_activity_led_n)
            else $error("activity not shown");
    AST_ACT_RELEASE:
        assert property (rcnt > LAMP_CYCLES + STRETCH_CYCLES + 24'h4
            && icnt == STRETCH_CYCLES + 24'h3 |-> any_activity_led_n)
            else $error("activity held too long");
    AST_COL_HOLD:
        assert property (s_col_end |-> ##1 (!any_collision_led_n) [*8])
            else $error("collision not stretched");
    AST_ALERT_MIN:
        assert property ($fell(alert_led_n) |-> (!alert_led_n) [*8])
            else $error("alert too short");
    AST_ALERT_PART:
        assert property (rcnt > LAMP_CYCLES + LONG_CYCLES + 24'h4
            && pcnt == LONG_CYCLES + 24'h4 |-> !alert_led_n)
            else $error("alert missing on long partition");
endmodule

bind rsl_ctrl rsl_ctrl_checker #(.LAMP_CYCLES(LAMP_CYCLES), .LONG_CYCLES(LONG_CYCLES),
    .STRETCH_CYCLES(STRETCH_CYCLES)) u_chk (.clk, .reset_n, .reset_source_select,
    .ext_reset_in_n, .port_rx_act, .port_collision, .port_link_ok, .port_partitioned,
    .repeater_run_q, .traffic_bar_led_n, .alert_led_n, .any_activity_led_n,
    .any_collision_led_n, .compat_led_n, .port_led_a, .port_led_b);

`default_nettype wire

/* dv/rsl_ctrl_tb.sv */
/*
 * Self-checking bench for rsl_ctrl with shortened intervals.
 * Assumes the LED panel model and the bound checker are compiled alongside.
 */
`default_nettype none

module rsl_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [23:0] LAMP = 24'h32;
    localparam logic [23:0] LONG = 24'h28;
    localparam logic [23:0] STR = 24'h0a;
    localparam logic [23:0] AMIN = 24'h0c;
    localparam logic [23:0] WIN = 24'hc8;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic reset_source_select = 1'b0;
    logic pulse_req = 1'b0;
    logic [7:0] port_carrier = 8'h00;
    logic [7:0] port_rx_act = 8'h00;
    logic [7:0] port_collision = 8'h00;
    logic [7:0] port_link_ok = 8'h00;
    logic [7:0] port_partitioned = 8'h00;
    wire logic ext_reset_in_n;
    wire logic repeater_run_q;
    wire logic alert_led_n;
    wire logic any_activity_led_n;
    wire logic any_collision_led_n;
    wire logic [7:0] traffic_bar_led_n;
    wire logic [7:0] compat_led_n;
    wire logic [7:0] port_led_a;
    wire logic [7:0] port_led_b;
    wire logic [7:0] colour1_lit;
    wire logic [7:0] colour2_lit;
    int miscompares = 0;
    int samples_checked = 0;

    always #50 clk = ~clk;

    rsl_ctrl #(.LAMP_CYCLES(LAMP), .LONG_CYCLES(LONG), .STRETCH_CYCLES(STR),
        .ALERT_MIN_CYCLES(AMIN), .WIN_CYCLES(WIN)) dut (.clk, .reset_n,
        .reset_source_select, .ext_reset_in_n, .port_carrier, .port_rx_act,
        .port_collision, .port_link_ok, .port_partitioned, .repeater_run_q,
        .traffic_bar_led_n, .alert_led_n, .any_activity_led_n, .any_collision_led_n,
        .compat_led_n, .port_led_a, .port_led_b);

    rsl_led_panel panel (.clk, .pulse_req, .port_led_a, .port_led_b, .ext_reset_in_n,
        .colour1_lit, .colour2_lit);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_run(input logic v);
        int i;
        for (i = 0; i < 200 && repeater_run_q !== v; i++)
            tick(1);
        check("run", 8'(repeater_run_q), 8'(v));
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_power_on();
        tick(3);
        check("compat", compat_led_n, 8'hff);
        check("bar", traffic_bar_led_n, 8'h00);
        wait_run(1'b1);
        check("port_b", port_led_b, 8'h00);
        tick(int'(LAMP) - 2);
        check("compat", compat_led_n, 8'h00);
        tick(3);
        check("compat", compat_led_n, 8'hff);
        check("bar", traffic_bar_led_n, 8'hff);
    endtask

    task automatic t_ports();
        logic [7:0] lk [3] = '{8'hff, 8'ha5, 8'h3c};
        logic [7:0] pt [3] = '{8'h00, 8'h0f, 8'hf0};
        int i;
        for (i = 0; i < 3; i++)
        begin
            port_link_ok = lk[i];
            port_partitioned = pt[i];
            tick(2);
            check("colour1", colour1_lit, lk[i] & ~pt[i]);
            check("colour2", colour2_lit, lk[i] & pt[i]);
        end
        port_partitioned = 8'h00;
    endtask

    task automatic t_stretch(input logic use_col);
        port_collision = use_col ? 8'h10 : 8'h00;
        port_rx_act = use_col ? 8'h00 : 8'h10;
        tick(3);
        check("led", 8'(use_col ? any_collision_led_n : any_activity_led_n), 8'h00);
        port_collision = 8'h00;
        port_rx_act = 8'h00;
        tick(int'(STR) - 3);
        check("hold", 8'(use_col ? any_collision_led_n : any_activity_led_n), 8'h00);
        tick(8);
        check("off", 8'(use_col ? any_collision_led_n : any_activity_led_n), 8'h01);
    endtask

    task automatic t_alert_part();
        port_link_ok = 8'hff;
        port_partitioned = 8'h40;
        tick(int'(LONG) - 10);
        check("alert", 8'(alert_led_n), 8'h01);
        port_partitioned = 8'h00;
        tick(2);
        port_partitioned = 8'h40;
        tick(int'(LONG) + 6);
        check("alert", 8'(alert_led_n), 8'h00);
        port_partitioned = 8'h00;
        tick(3);
        check("alert", 8'(alert_led_n), 8'h00);
        tick(int'(AMIN) + 4);
        check("alert", 8'(alert_led_n), 8'h01);
    endtask

    // Duty patterns chosen so either window alignment lands between thresholds
    task automatic t_bar();
        int per [8] = '{40, 40, 10, 10, 10, 10, 10, 40};
        int on [8] = '{1, 2, 1, 2, 4, 6, 9, 0};
        logic [7:0] bar [8] = '{8'hfc, 8'hf8, 8'hf0, 8'he0, 8'hc0, 8'h80, 8'h00, 8'hff};
        int i;
        int c;
        for (i = 0; i < 8; i++)
        begin
            for (c = 0; c < 3 * int'(WIN); c++)
            begin
                port_carrier = (c % per[i] < on[i]) ? 8'h01 << (c % 8) : 8'h00;
                tick(1);
            end
            check("bar", traffic_bar_led_n, bar[i]);
            check("alert", 8'(alert_led_n), 8'(i != 6));
        end
    endtask

    task automatic t_ext_reset();
        port_link_ok = 8'h5a;
        pulse_req = 1'b1;
        tick(1);
        pulse_req = 1'b0;
        tick(10);
        check("run", 8'(repeater_run_q), 8'h01);
        reset_source_select = 1'b1;
        tick(3);
        check("run", 8'(repeater_run_q), 8'h01);
        pulse_req = 1'b1;
        tick(1);
        pulse_req = 1'b0;
        wait_run(1'b0);
        check("compat", compat_led_n, 8'hff);
        check("port_b", port_led_b, 8'h00);
        wait_run(1'b1);
        check("compat", compat_led_n, 8'h00);
        tick(int'(LAMP) + 1);
        check("compat", compat_led_n, 8'ha5);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(8);
        reset_n = 1'b1;
        t_power_on();
        t_ports();
        t_stretch(1'b0);
        t_stretch(1'b1);
        t_alert_part();
        t_bar();
        t_ext_reset();
        summarize();
    end

    initial
    begin
        #1000000;
        miscompares++;
        summarize();
    end
endmodule

`default_nettype wire

/* dv/rsl_led_panel.sv */
/*
 * Far-side model: bicolour LED pairs and a clean external reset source.
 * Assumes pulse_req is driven by the bench and sampled on the rising clock edge.
 */
`default_nettype none

module rsl_led_panel #(
    parameter int PULSE_CYCLES = 6
) (
    input wire logic clk,
    input wire logic pulse_req,
    input wire logic [7:0] port_led_a,
    input wire logic [7:0] port_led_b,
    output logic ext_reset_in_n,
    output logic [7:0] colour1_lit,
    output logic [7:0] colour2_lit
);
    int left = 0;

    // Glitch-free low pulse; the idle level stands for an open pin
    always @(posedge clk)
    begin
        if (pulse_req)
            left <= PULSE_CYCLES;
        else if (left != 0)
            left <= left - 1;
    end

    assign ext_reset_in_n = (left == 0);

    // Current through the two-lead LED decides the colour
    assign colour1_lit = port_led_a & ~port_led_b;
    assign colour2_lit = ~port_led_a & port_led_b;
endmodule

`default_nettype wire

/* hdl/rsl_ctrl.v */
/*
 * Status indication logic of an eight-port repeater: reset source
 * selection, lamp test, traffic bargraph, alert, global activity and
 * collision stretchers, and per-port bicolour link/partition indicators.
 * Assumes all inputs except reset_n are synchronous to clk; indicator pins are push-pull.
 */
`default_nettype none
`include "rsl_regs.vh"

module rsl_ctrl #(
    parameter [`RSL_CTR_W-1:0] LAMP_CYCLES = `RSL_LAMP_TEST_MS * `RSL_CYC_PER_MS,
    parameter [`RSL_CTR_W-1:0] LONG_CYCLES = `RSL_LONG_COND_MS * `RSL_CYC_PER_MS,
    parameter [`RSL_CTR_W-1:0] STRETCH_CYCLES = `RSL_STRETCH_MS * `RSL_CYC_PER_MS,
    parameter [`RSL_CTR_W-1:0] ALERT_MIN_CYCLES = `RSL_ALERT_MIN_MS * `RSL_CYC_PER_MS,
    parameter [`RSL_CTR_W-1:0] WIN_CYCLES = `RSL_SAMPLE_MS * `RSL_CYC_PER_MS
) (
    input wire clk,
    input wire reset_n,
    input wire reset_source_select,
    input wire ext_reset_in_n,
    input wire [`RSL_NPORT-1:0] port_carrier,
    input wire [`RSL_NPORT-1:0] port_rx_act,
    input wire [`RSL_NPORT-1:0] port_collision,
    input wire [`RSL_NPORT-1:0] port_link_ok,
    input wire [`RSL_NPORT-1:0] port_partitioned,
    output reg repeater_run_q,
    output reg [`RSL_NPORT-1:0] traffic_bar_led_n,
    output reg alert_led_n,
    output reg any_activity_led_n,
    output reg any_collision_led_n,
    output reg [`RSL_NPORT-1:0] compat_led_n,
    output reg [`RSL_NPORT-1:0] port_led_a,
    output reg [`RSL_NPORT-1:0] port_led_b
);

    localparam [`RSL_CTR_W-1:0] CTR_ONE = {{(`RSL_CTR_W-1){1'b0}}, 1'b1};
    localparam [`RSL_CTR_W-1:0] CTR_ZERO = {`RSL_CTR_W{1'b0}};

    function [31:0] bar_pct;
        input integer idx;
        begin
            case (idx)
                0: bar_pct = `RSL_PCT_0;
                1: bar_pct = `RSL_PCT_1;
                2: bar_pct = `RSL_PCT_2;
                3: bar_pct = `RSL_PCT_3;
                4: bar_pct = `RSL_PCT_4;
                5: bar_pct = `RSL_PCT_5;
                6: bar_pct = `RSL_PCT_6;
                default: bar_pct = `RSL_PCT_7;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops
    reg rst_meta_q;
    reg rst_sync_q;

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Internal power-on reset and source selection
    reg [`RSL_CTR_W-1:0] por_cnt_q;
    reg por_done_q;
    wire sel_rst_n;

    always @(posedge clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            por_cnt_q <= CTR_ZERO;
            por_done_q <= 1'b0;
        end
        else if (por_cnt_q != `RSL_POR_CYCLES)
        begin
            por_cnt_q <= por_cnt_q + CTR_ONE;
        end
        else
        begin
            por_done_q <= 1'b1;
        end
    end

    // External pin assumed a clean pulse, used only when selected
    assign sel_rst_n = reset_source_select ? ext_reset_in_n : por_done_q;

    ////////////////////////////////////////////////////////////////////////////
    // Lamp-test sequencer
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [`RSL_CTR_W-1:0] lamp_q;
    reg [`RSL_CTR_W-1:0] lamp_d;

    always @*
    begin
        state_d = state_q;
        lamp_d = lamp_q;
        case (state_q)
            `RSL_ST_RESET:
            begin
                if (sel_rst_n)
                begin
                    state_d = `RSL_ST_TEST;
                    lamp_d = LAMP_CYCLES - CTR_ONE;
                end
            end
            `RSL_ST_TEST:
            begin
                if (lamp_q == CTR_ZERO)
                begin
                    state_d = `RSL_ST_RUN;
                end
                else
                begin
                    lamp_d = lamp_q - CTR_ONE;
                end
            end
            `RSL_ST_RUN:
            begin
                state_d = `RSL_ST_RUN;
            end
            default:
            begin
                state_d = `RSL_ST_RESET;
            end
        endcase
        if (!sel_rst_n)
        begin
            state_d = `RSL_ST_RESET;
            lamp_d = CTR_ZERO;
        end
    end

    always @(posedge clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            state_q <= `RSL_ST_RESET;
            lamp_q <= CTR_ZERO;
        end
        else
        begin
            state_q <= state_d;
            lamp_q <= lamp_d;
        end
    end

    wire in_reset = (state_d == `RSL_ST_RESET);
    wire in_test = (state_d == `RSL_ST_TEST);
    wire force_lit = in_reset | in_test;

    ////////////////////////////////////////////////////////////////////////////
    // Traffic sampling window
    reg [`RSL_CTR_W-1:0] win_q;
    reg [`RSL_CTR_W-1:0] busy_q;
    reg [`RSL_NPORT-1:0] bar_q;
    wire carrier_any = |port_carrier;
    wire win_end = (win_q == WIN_CYCLES - CTR_ONE);
    wire [`RSL_NPORT-1:0] bar_d;

    genvar gi;
    generate
        for (gi = 0; gi < `RSL_NPORT; gi = gi + 1)
        begin : g_bar
            localparam [31:0] THR_W = (WIN_CYCLES * bar_pct(gi)) / `RSL_PCT_DIV;
            localparam [`RSL_CTR_W-1:0] THR = THR_W[`RSL_CTR_W-1:0];
            if (gi == `RSL_TOP_BAR)
            begin : g_top
                assign bar_d[gi] = (busy_q > THR);
            end
            else
            begin : g_low
                assign bar_d[gi] = (busy_q >= THR);
            end
        end
    endgenerate

    always @(posedge clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            win_q <= CTR_ZERO;
            busy_q <= CTR_ZERO;
            bar_q <= {`RSL_NPORT{1'b0}};
        end
        else if (win_end)
        begin
            win_q <= CTR_ZERO;
            busy_q <= CTR_ZERO;
            bar_q <= bar_d;
        end
        else
        begin
            win_q <= win_q + CTR_ONE;
            if (carrier_any)
            begin
                busy_q <= busy_q + CTR_ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Long-condition timers: high traffic and per-port partition
    reg [`RSL_CTR_W-1:0] hi_cnt_q;
    wire hi_long = (hi_cnt_q == LONG_CYCLES);
    wire [`RSL_NPORT-1:0] part_long;

    always @(posedge clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            hi_cnt_q <= CTR_ZERO;
        end
        else if (!bar_q[`RSL_TOP_BAR])
        begin
            hi_cnt_q <= CTR_ZERO;
        end
        else if (!hi_long)
        begin
            hi_cnt_q <= hi_cnt_q + CTR_ONE;
        end
    end

    generate
        for (gi = 0; gi < `RSL_NPORT; gi = gi + 1)
        begin : g_part
            reg [`RSL_CTR_W-1:0] pcnt_q;
            assign part_long[gi] = (pcnt_q == LONG_CYCLES);
            always @(posedge clk or negedge rst_sync_q)
            begin
                if (!rst_sync_q)
                begin
                    pcnt_q <= CTR_ZERO;
                end
                else if (!port_partitioned[gi])
                begin
                    pcnt_q <= CTR_ZERO;
                end
                else if (!part_long[gi])
                begin
                    pcnt_q <= pcnt_q + CTR_ONE;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Alert with minimum on-time counted from activation
    wire alert_cond = hi_long | (|part_long);
    reg alert_q;
    reg [`RSL_CTR_W-1:0] amin_q;

    always @(posedge clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            alert_q <= 1'b0;
            amin_q <= CTR_ZERO;
        end
        else if (!alert_q)
        begin
            if (alert_cond)
            begin
                alert_q <= 1'b1;
                amin_q <= ALERT_MIN_CYCLES - CTR_ONE;
            end
        end
        else if (amin_q != CTR_ZERO)
        begin
            amin_q <= amin_q - CTR_ONE;
        end
        else if (!alert_cond)
        begin
            alert_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Global activity and collision stretchers
    wire act_led_n;
    wire col_led_n;

    rsl_stretch #(
        .HOLD_CYCLES(STRETCH_CYCLES)
    ) u_act (
        .clk(clk),
        .rst_n(rst_sync_q),
        .ev(|port_rx_act),
        .led_n_q(act_led_n)
    );

    rsl_stretch #(
        .HOLD_CYCLES(STRETCH_CYCLES)
    ) u_col (
        .clk(clk),
        .rst_n(rst_sync_q),
        .ev(|port_collision),
        .led_n_q(col_led_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output stage: lamp-test override and per-port bicolour drive
    generate
        for (gi = 0; gi < `RSL_NPORT; gi = gi + 1)
        begin : g_port
            always @(posedge clk or negedge rst_sync_q)
            begin
                if (!rst_sync_q)
                begin
                    port_led_a[gi] <= 1'b1;
                    port_led_b[gi] <= 1'b0;
                    compat_led_n[gi] <= 1'b1;
                end
                else
                begin
                    compat_led_n[gi] <= in_reset ? 1'b1 :
                        (in_test ? 1'b0 : ~port_link_ok[gi]);
                    if (force_lit)
                    begin
                        port_led_a[gi] <= 1'b1;
                        port_led_b[gi] <= 1'b0;
                    end
                    else if (!port_link_ok[gi])
                    begin
                        port_led_a[gi] <= 1'b1;
                        port_led_b[gi] <= 1'b1;
                    end
                    else
                    begin
                        port_led_a[gi] <= ~port_partitioned[gi];
                        port_led_b[gi] <= port_partitioned[gi];
                    end
                end
            end
        end
    endgenerate

    always @(posedge clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            repeater_run_q <= 1'b0;
            traffic_bar_led_n <= {`RSL_NPORT{1'b0}};
            alert_led_n <= 1'b0;
            any_activity_led_n <= 1'b0;
            any_collision_led_n <= 1'b0;
        end
        else
        begin
            repeater_run_q <= ~in_reset;
            if (force_lit)
            begin
                traffic_bar_led_n <= {`RSL_NPORT{1'b0}};
                alert_led_n <= 1'b0;
                any_activity_led_n <= 1'b0;
                any_collision_led_n <= 1'b0;
            end
            else
            begin
                traffic_bar_led_n <= ~bar_q;
                alert_led_n <= ~alert_q;
                any_activity_led_n <= act_led_n;
                any_collision_led_n <= col_led_n;
            end
        end
    end

endmodule

`default_nettype wire

/* hdl/rsl_regs.vh */
/*
 * Constants for the repeater status and LED controller.
 * Assumes one 10 MHz clock; all intervals except the power-on count RSL_POR_CYCLES are derived from CLK_HZ.
 */
// Notes on behaviour
// - Internal power-on reset runs by itself, then repeater operation starts.
// - A select input picks internal power-on reset or external reset pin.
// - Rising edge of the selected reset starts a one-second lamp test.
// - Lamp test lights all single, legacy and bicolour A-side outputs.
// - Direct indicators stay lit during reset and one second after it.
// - Legacy indicators dark in reset, all lit during the one-second test, then lit for link up.
// - Eight bar outputs: 1,2,3,6,12,25,50 percent, top above 80 percent.
// - Combined carrier of all ports sampled at 6.25 Hz versus maximum.
// - Bargraph in fill style: all outputs up to current level lit.
// - Alert when traffic over 80 percent or a port partitioned for 1 s.
// - Alert stays until its cause ends, but at least 30 ms.
// - Activity and collision outputs show any port's activity or collision.
// - After an event ends its output holds 30 ms or until next event.
// - Each bicolour indicator uses two pins, each driven high or low.
// - Link and partition indicator logic repeated identically for ports 1-8.
// - Link down dark; link up colour one, or colour two if partitioned.
`ifndef RSL_REGS_VH
`define RSL_REGS_VH

`define RSL_CLK_HZ 10000000
`define RSL_CYC_PER_MS (`RSL_CLK_HZ / 1000)
`define RSL_CTR_W 24
`define RSL_NPORT 8

`define RSL_LAMP_TEST_MS 1000
`define RSL_LONG_COND_MS 1000
`define RSL_STRETCH_MS 30
`define RSL_ALERT_MIN_MS 30
`define RSL_SAMPLE_MS 160
`define RSL_POR_CYCLES 24'h000010

`define RSL_PCT_DIV 100
`define RSL_PCT_0 1
`define RSL_PCT_1 2
`define RSL_PCT_2 3
`define RSL_PCT_3 6
`define RSL_PCT_4 12
`define RSL_PCT_5 25
`define RSL_PCT_6 50
`define RSL_PCT_7 80
`define RSL_TOP_BAR 7

`define RSL_ST_RESET 3'h1
`define RSL_ST_TEST 3'h2
`define RSL_ST_RUN 3'h4

`endif

/* hdl/rsl_stretch.v */
/*
 * Event stretcher for an active-low indicator.
 * Assumes ev is synchronous to clk; rst_n is the synchronised reset.
 */
`default_nettype none
`include "rsl_regs.vh"

module rsl_stretch #(
    parameter [`RSL_CTR_W-1:0] HOLD_CYCLES = `RSL_STRETCH_MS * `RSL_CYC_PER_MS
) (
    input wire clk,
    input wire rst_n,
    input wire ev,
    output reg led_n_q
);

    reg [`RSL_CTR_W-1:0] hold_q;
    reg [`RSL_CTR_W-1:0] hold_d;
    reg led_n_d;

    ////////////////////////////////////////////////////////////////////////////
    // Lit while the event lasts, then for HOLD_CYCLES; a new event reloads
    always @*
    begin
        hold_d = hold_q;
        led_n_d = led_n_q;
        if (ev)
        begin
            hold_d = HOLD_CYCLES;
            led_n_d = 1'b0;
        end
        else if (hold_q != {`RSL_CTR_W{1'b0}})
        begin
            hold_d = hold_q - {{(`RSL_CTR_W-1){1'b0}}, 1'b1};
            led_n_d = 1'b0;
        end
        else
        begin
            led_n_d = 1'b1;
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_q <= {`RSL_CTR_W{1'b0}};
            led_n_q <= 1'b1;
        end
        else
        begin
            hold_q <= hold_d;
            led_n_q <= led_n_d;
        end
    end

endmodule

`default_nettype wire
